// ### rtl/ppl_loader.sv
// pixel payload assembler: skips header registers, emits padding, constant and setup registers
`include "ppl_cfg.svh"
module ppl_loader #(
    parameter int REG_W = `PPL_REG_W
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire ppl_pkg::ppl_cmd_t cmd,
    input wire logic cmd_valid,
    output logic cmd_ready,
    output logic [`PPL_ADDR_W-1:0] rd_addr,
    output logic rd_valid,
    input wire logic rd_ready,
    input wire logic [REG_W-1:0] rd_data,
    input wire logic rd_data_valid,
    output ppl_pkg::ppl_word_t out_word,
    output logic out_valid,
    input wire logic out_ready,
    output logic busy
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_HDR,
        ST_PAD,
        ST_CONST,
        ST_SETUP,
        ST_WAIT
    } ppl_st_t;

    function automatic logic [`PPL_ADDR_W-1:0] entry_addr(
        input logic [`PPL_HDL_W-1:0] hdl,
        input logic [`PPL_LEN_W-1:0] off,
        input logic [`PPL_LEN_W-1:0] idx);
        entry_addr = {hdl, off} + {{(`PPL_ADDR_W-`PPL_LEN_W){1'b0}}, idx};
    endfunction : entry_addr

    ppl_st_t st_q, st_d;
    ppl_pkg::ppl_cmd_t cmd_q, cmd_d;
    logic [`PPL_REGNUM_W-1:0] reg_q, reg_d;
    logic [`PPL_LEN_W-1:0] idx_q, idx_d;
    logic [1:0] pend_q, pend_d;
    ppl_pkg::ppl_word_t buf_q [2];
    ppl_pkg::ppl_word_t buf_d [2];
    logic [1:0] cnt_q, cnt_d;
    ppl_pkg::ppl_word_t push_w;
    logic push;
    logic pop;
    logic room;
    logic const_last;
    logic setup_none;
    logic [`PPL_REGNUM_W-1:0] reg_inc;
    logic [`PPL_REGNUM_W-1:0] const_end;

    assign cmd_ready = (st_q == ST_IDLE);
    assign busy = (st_q != ST_IDLE);
    assign out_valid = (cnt_q != 2'h0);
    assign out_word = buf_q[0];
    assign pop = out_valid && out_ready;
    // reserve slots for reads already in flight
    assign room = ({1'b0, cnt_q} + {1'b0, pend_q}) < 3'h2;
    assign setup_none = (cmd_q.setup_len == '0);
    assign const_last = (idx_q == cmd_q.const_len - 6'h01) && setup_none;
    assign reg_inc = reg_q + 7'h01;
    // first register past the constant section; returned reads below it are constant data
    assign const_end = cmd_q.start_reg + (cmd_q.const_en ? {1'b0, cmd_q.const_len} : 7'h00);

    always_comb begin
        st_d = st_q;
        cmd_d = cmd_q;
        reg_d = reg_q;
        idx_d = idx_q;
        pend_d = pend_q;
        rd_valid = 1'b0;
        rd_addr = '0;
        push = 1'b0;
        push_w = '0;
        if (rd_data_valid) begin
            push = 1'b1;
            push_w.data = rd_data;
            push_w.reg_num = reg_q - {5'h0, pend_q};
            push_w.src = (push_w.reg_num < const_end) ? ppl_pkg::PPL_SRC_CONST : ppl_pkg::PPL_SRC_SETUP;
            pend_d = pend_q - 2'h1;
        end
        unique case (st_q)
            ST_IDLE: begin
                if (cmd_valid) begin
                    cmd_d = cmd;
                    reg_d = `PPL_HDR_LEAD;
                    idx_d = '0;
                    st_d = ST_HDR;
                end
            end
            ST_HDR: begin
                // header words are written by the dispatcher; only advance past them
                if (reg_q > cmd_q.hdr_regs) begin
                    st_d = ST_PAD;
                end else begin
                    reg_d = reg_inc;
                end
            end
            ST_PAD: begin
                if (reg_q >= cmd_q.start_reg) begin
                    st_d = (cmd_q.const_en && cmd_q.const_len != '0) ? ST_CONST :
                           (!setup_none ? ST_SETUP : ST_IDLE);
                end else if (room && !rd_data_valid) begin
                    push = 1'b1;
                    push_w.reg_num = reg_q;
                    push_w.src = ppl_pkg::PPL_SRC_PAD;
                    push_w.data = `PPL_PAD_DATA;
                    push_w.last = 1'b0;
                    reg_d = reg_inc;
                end
            end
            ST_CONST: begin
                rd_valid = room;
                rd_addr = entry_addr(cmd_q.const_handle, cmd_q.const_off, idx_q);
                if (room && rd_ready) begin
                    pend_d = pend_d + 2'h1;
                    reg_d = reg_inc;
                    if (idx_q == cmd_q.const_len - 6'h01) begin
                        idx_d = '0;
                        st_d = setup_none ? ST_WAIT : ST_SETUP;
                    end else begin
                        idx_d = idx_q + 6'h01;
                    end
                end
            end
            ST_SETUP: begin
                rd_valid = room;
                rd_addr = entry_addr(cmd_q.setup_handle, cmd_q.setup_off, idx_q);
                if (room && rd_ready) begin
                    pend_d = pend_d + 2'h1;
                    reg_d = reg_inc;
                    if (idx_q == cmd_q.setup_len - 6'h01) begin
                        st_d = ST_WAIT;
                    end else begin
                        idx_d = idx_q + 6'h01;
                    end
                end
            end
            ST_WAIT: begin
                if (pend_d == 2'h0) begin
                    st_d = ST_IDLE;
                end
            end
            default: st_d = ST_IDLE;
        endcase
        // the final read of the payload marks the last word
        if (rd_data_valid && pend_q == 2'h1 && (st_q == ST_WAIT)) begin
            push_w.last = 1'b1;
        end
    end

    always_comb begin
        buf_d = buf_q;
        cnt_d = cnt_q;
        if (pop) begin
            buf_d[0] = buf_q[1];
            cnt_d = cnt_d - 2'h1;
        end
        if (push) begin
            buf_d[cnt_d[0]] = push_w;
            cnt_d = cnt_d + 2'h1;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= ST_IDLE;
            cmd_q <= '0;
            reg_q <= '0;
            idx_q <= '0;
            pend_q <= 2'h0;
            buf_q[0] <= '0;
            buf_q[1] <= '0;
            cnt_q <= 2'h0;
        end else begin
            st_q <= st_d;
            cmd_q <= cmd_d;
            reg_q <= reg_d;
            idx_q <= idx_d;
            pend_q <= pend_d;
            buf_q <= buf_d;
            cnt_q <= cnt_d;
        end
    end

    logic unused_const_last;
    assign unused_const_last = const_last;

    sequence pad_push_s;
        push && push_w.src == ppl_pkg::PPL_SRC_PAD;
    endsequence

    pad_range_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        pad_push_s |-> push_w.reg_num < cmd_q.start_reg && push_w.data == '0)
        else $error("padding outside its range");

    const_start_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        st_q == ST_PAD && st_d == ST_CONST |-> reg_q == cmd_q.start_reg)
        else $error("constant data not at start register");

    const_addr_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        rd_valid && st_q == ST_CONST |->
            rd_addr == {cmd_q.const_handle, cmd_q.const_off} + 16'(reg_q - cmd_q.start_reg))
        else $error("constant read address wrong");

    data_pass_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        rd_data_valid && cnt_q == 2'h0 |=> out_word.data == $past(rd_data))
        else $error("read data altered");

    setup_after_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        st_q == ST_SETUP |-> reg_q == const_end + {1'b0, idx_q})
        else $error("setup data before constant data");

    setup_addr_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        rd_valid && st_q == ST_SETUP |->
            rd_addr == {cmd_q.setup_handle, cmd_q.setup_off} + 16'(reg_q - const_end))
        else $error("setup handle not used");

    setup_len_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        st_q == ST_SETUP |-> idx_q < cmd_q.setup_len)
        else $error("setup read past length");

    order_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        st_q == ST_CONST |=> st_q inside {ST_CONST, ST_SETUP, ST_WAIT})
        else $error("section order broken");

    buf_full_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cnt_q == 2'h2 |-> !push || pop)
        else $error("buffer overrun");
endmodule : ppl_loader

// ### include/ppl_cfg.svh
// constants for the pixel payload buffer-data loader
`ifndef PPL_CFG_SVH
`define PPL_CFG_SVH
`define PPL_REG_DW 8
`define PPL_DW_W 32
`define PPL_REG_W 256
`define PPL_REGNUM_W 7
`define PPL_LEN_W 6
`define PPL_HDL_W 10
`define PPL_ADDR_W 16
`define PPL_PAD_DATA 256'h0
`define PPL_HDR_LEAD 7'h01
`endif

// ### include/ppl_pkg.sv
// types for the pixel payload buffer-data loader
`include "ppl_cfg.svh"
package ppl_pkg;
    typedef enum logic [2:0] {
        PPL_SRC_HDR,
        PPL_SRC_PAD,
        PPL_SRC_CONST,
        PPL_SRC_SETUP
    } ppl_src_t;

    typedef struct packed {
        logic [`PPL_REGNUM_W-1:0] hdr_regs;
        logic [`PPL_REGNUM_W-1:0] start_reg;
        logic const_en;
        logic [`PPL_LEN_W-1:0] const_off;
        logic [`PPL_LEN_W-1:0] const_len;
        logic [`PPL_LEN_W-1:0] setup_off;
        logic [`PPL_LEN_W-1:0] setup_len;
        logic [`PPL_HDL_W-1:0] const_handle;
        logic [`PPL_HDL_W-1:0] setup_handle;
    } ppl_cmd_t;

    typedef struct packed {
        logic [`PPL_REGNUM_W-1:0] reg_num;
        ppl_src_t src;
        logic last;
        logic [`PPL_REG_W-1:0] data;
    } ppl_word_t;
endpackage : ppl_pkg

// ### testbench/ppl_buf_model.sv
// shared entry buffer model answering register reads
`include "ppl_cfg.svh"
module ppl_buf_model (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [`PPL_ADDR_W-1:0] rd_addr,
    input wire logic rd_valid,
    output logic rd_ready,
    output logic [`PPL_REG_W-1:0] rd_data,
    output logic rd_data_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [`PPL_ADDR_W-1:0] pend_q[$];
    int seed = 32'h4b3f;
    initial begin
        rd_ready = 1'b0;
        rd_data = '0;
        rd_data_valid = 1'b0;
    end
    always @(posedge ref_clk) begin
        if (!sys_rst && rd_valid === 1'b1 && rd_ready === 1'b1) begin
            pend_q.push_back(rd_addr);
        end
    end
    always @(negedge ref_clk) begin
        rd_ready = 1'($random(seed));
        rd_data_valid = 1'b0;
        rd_data = ~rd_data;
        if (pend_q.size() != 0 && $random(seed) % 2 == 0) begin
            rd_data = {16{pend_q.pop_front()}};
            rd_data_valid = 1'b1;
        end
    end
endmodule : ppl_buf_model

// ### testbench/testbench.sv
// self-checking testbench for the payload loader
`include "ppl_cfg.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0, sys_rst = 1, cmd_valid = 0, out_ready = 0;
    logic cmd_ready, rd_valid, rd_ready, rd_data_valid, out_valid, busy;
    logic [`PPL_ADDR_W-1:0] rd_addr;
    logic [`PPL_REG_W-1:0] rd_data;
    ppl_pkg::ppl_cmd_t cmd = '0, c;
    ppl_pkg::ppl_word_t out_word, m, exp_q[$];
    int failures = 0, n_tests = 0, seed = 32'h4b3f;
    always #2 ref_clk = ~ref_clk;
    ppl_loader u_ppl_loader (.ref_clk(ref_clk), .sys_rst(sys_rst), .cmd(cmd), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_ready(rd_ready),
        .rd_data(rd_data), .rd_data_valid(rd_data_valid), .out_word(out_word), .out_valid(out_valid),
        .out_ready(out_ready), .busy(busy));
    ppl_buf_model u_ppl_buf_model (.ref_clk(ref_clk), .sys_rst(sys_rst), .rd_addr(rd_addr),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .rd_data_valid(rd_data_valid));
    task automatic tally_and_finish;
        $display("mismatches %0d checks %0d", failures, n_tests);
        if (failures == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    task automatic note(input logic [6:0] r, input ppl_pkg::ppl_src_t s, input logic [15:0] a);
        ppl_pkg::ppl_word_t e;
        e.reg_num = r;
        e.src = s;
        e.last = 1'b0;
        e.data = (s == ppl_pkg::PPL_SRC_PAD) ? `PPL_PAD_DATA : {16{a}};
        exp_q.push_back(e);
    endtask : note
    task automatic run(input int t);
        logic [6:0] r;
        int i, n, k;
        r = c.hdr_regs + 7'h01;
        while (r < c.start_reg) begin
            note(r, ppl_pkg::PPL_SRC_PAD, 16'h0);
            r++;
        end
        n = c.const_en ? c.const_len : 0;
        for (i = 0; i < n; i++) begin
            note(r + 7'(i), ppl_pkg::PPL_SRC_CONST, {c.const_handle, c.const_off} + 16'(i));
        end
        r = r + 7'(n);
        for (i = 0; i < c.setup_len; i++) begin
            note(r + 7'(i), ppl_pkg::PPL_SRC_SETUP, {c.setup_handle, c.setup_off} + 16'(i));
        end
        if (n + c.setup_len > 0) begin
            exp_q[exp_q.size()-1].last = 1'b1;
        end
        cmd = c;
        cmd_valid = 1'b1;
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        for (k = 0; k < 500 && (exp_q.size() != 0 || busy !== 1'b0); k++) begin
            @(negedge ref_clk);
        end
        if (k == 500) begin
            failures++;
            $display("BAD %0t payload did not complete", $time);
        end
        $display("test %0d done", t);
    endtask : run
    always @(negedge ref_clk) out_ready = 1'($random(seed));
    always @(posedge ref_clk) begin
        if (out_valid === 1'b1 && out_ready === 1'b1) begin
            n_tests++;
            if (exp_q.size() == 0) begin
                failures++;
                $display("BAD %0t unexpected word", $time);
            end else begin
                m = exp_q.pop_front();
                if (out_word !== m) begin
                    failures++;
                    $display("BAD %0t word reg %0d differs", $time, m.reg_num);
                end
            end
        end
    end
    initial begin
        #100us;
        failures++;
        $display("BAD %0t watchdog expired", $time);
        tally_and_finish();
    end
    initial begin
        repeat (10) @(negedge ref_clk);
        sys_rst = 1'b0;
        for (int t = 0; t < 16; t++) begin
            c = 59'({$random(seed), $random(seed)});
            c.hdr_regs = {5'h0, 2'(t)};
            c.start_reg = c.hdr_regs + 7'h01 + {5'h0, 2'(t >> 2)};
            c.const_len = {4'h0, 2'($random(seed))};
            c.setup_len = {4'h0, 2'($random(seed))};
            run(t);
        end
        tally_and_finish();
    end
endmodule : testbench
